// file: fcc_pkg.sv
package fcc_pkg;
	localparam int NUM_CLASS = 3;
	localparam int CLS_W     = 2;
	localparam int HDR_W     = 8;
	localparam int DATA_W    = 12;

	typedef logic [HDR_W-1:0]  fcc_hdr_t;
	typedef logic [DATA_W-1:0] fcc_data_t;
	typedef logic [CLS_W-1:0]  fcc_cls_t;

	localparam fcc_cls_t CLS_POSTED    = 2'h0;
	localparam fcc_cls_t CLS_NONPOSTED = 2'h1;
	localparam fcc_cls_t CLS_CPL       = 2'h2;

	// receive buffer space per class, in credits
	localparam fcc_hdr_t  RX_HDR_TOTAL  [NUM_CLASS] = '{8'h20, 8'h20, 8'h20};
	localparam fcc_data_t RX_DATA_TOTAL [NUM_CLASS] = '{12'h080, 12'h040,
		12'h100};
	localparam fcc_data_t MAX_PAYLOAD_CRED = 12'h008;
	localparam fcc_hdr_t  HDR_CRED_PER_TLP = 8'h01;

	localparam int CLK_PERIOD_PS = 8000;
	localparam int UPD_TIMER_US  = 30;
	localparam int UPD_TIMER_CYC = UPD_TIMER_US * 1000000 / CLK_PERIOD_PS;
	localparam int DRAIN_MIN_NS  = 60;
	localparam int DRAIN_MAX_NS  = 68;
	localparam int DRAIN_CYC     = (DRAIN_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int DRAIN_HOLD    = DRAIN_CYC - 2;
	localparam int FCU_MIN_NS    = 116;
	localparam int FCU_MAX_NS    = 160;
	localparam int FCU_CYC       = (FCU_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int FCU_STAGES    = FCU_CYC - 1;
	localparam int TIMER_W       = 12;
	localparam int HOLD_W        = 3;

	typedef enum logic {UPD_IDLE, UPD_HOLD} fcc_upd_state_e;
endpackage

`timescale 1ns/1ns
module fcc_rx_class import fcc_pkg::*; #(
	parameter fcc_hdr_t  HDR_TOTAL  = 8'h20,
	parameter fcc_data_t DATA_TOTAL = 12'h080
) (
	input  wire logic      i_clock,
	input  wire logic      i_sys_rst,
	input  wire logic      i_clk_en,
	input  wire logic      i_drain,
	input  wire fcc_hdr_t  i_drain_hdr,
	input  wire fcc_data_t i_drain_data,
	input  wire logic      i_recv,
	input  wire fcc_data_t i_recv_data,
	input  wire logic      i_sent,
	output fcc_hdr_t       o_alloc_hdr,
	output fcc_data_t      o_alloc_data,
	output logic           o_req,
	output logic           o_hi
);
	localparam logic [TIMER_W-1:0] TMAX  = TIMER_W'(UPD_TIMER_CYC);
	localparam logic [HOLD_W-1:0]  HLOAD = HOLD_W'(DRAIN_HOLD);
	localparam fcc_data_t QTR_DATA = DATA_TOTAL >> 2;
	localparam fcc_hdr_t  QTR_HDR  = HDR_TOTAL >> 2;

	fcc_hdr_t            alloc_hdr_reg, alloc_hdr_next, last_hdr_reg, last_hdr_next;
	fcc_data_t           alloc_data_reg, alloc_data_next;
	fcc_data_t           last_data_reg, last_data_next;
	fcc_data_t           recv_reg, recv_next;
	logic [TIMER_W-1:0]  timer_reg, timer_next;
	logic [HOLD_W-1:0]   hold_reg, hold_next;
	logic                pend_reg, pend_next;
	logic                expired, starve, quarter;

	always_comb begin
		alloc_hdr_next  = alloc_hdr_reg;
		alloc_data_next = alloc_data_reg;
		last_hdr_next   = last_hdr_reg;
		last_data_next  = last_data_reg;
		recv_next       = i_recv ? recv_reg + i_recv_data : recv_reg;
		timer_next      = (timer_reg == TMAX) ? timer_reg : timer_reg + 1'b1;
		hold_next       = (hold_reg != '0) ? hold_reg - 1'b1 : hold_reg;
		pend_next       = pend_reg;
		if (i_sent) begin
			last_hdr_next  = alloc_hdr_reg;
			last_data_next = alloc_data_reg;
			recv_next      = i_recv ? i_recv_data : '0;
			timer_next     = '0;
			pend_next      = 1'b0;
		end
		if (i_drain) begin
			alloc_hdr_next  = alloc_hdr_reg + i_drain_hdr;
			alloc_data_next = alloc_data_reg + i_drain_data;
			hold_next       = HLOAD;
			pend_next       = 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			alloc_hdr_reg  <= HDR_TOTAL;
			alloc_data_reg <= DATA_TOTAL;
			last_hdr_reg   <= HDR_TOTAL;
			last_data_reg  <= DATA_TOTAL;
			recv_reg       <= '0;
			timer_reg      <= '0;
			hold_reg       <= '0;
			pend_reg       <= 1'b0;
		end else if (i_clk_en) begin
			alloc_hdr_reg  <= alloc_hdr_next;
			alloc_data_reg <= alloc_data_next;
			last_hdr_reg   <= last_hdr_next;
			last_data_reg  <= last_data_next;
			recv_reg       <= recv_next;
			timer_reg      <= timer_next;
			hold_reg       <= hold_next;
			pend_reg       <= pend_next;
		end
	end

	assign expired = (timer_reg == TMAX);
	assign starve  = ((last_data_reg - recv_reg) < MAX_PAYLOAD_CRED)
		&& (alloc_data_reg != last_data_reg);
	assign quarter = ((alloc_data_reg - last_data_reg) >= QTR_DATA)
		|| ((alloc_hdr_reg - last_hdr_reg) >= QTR_HDR);
	assign o_req        = (pend_reg && hold_reg == '0) || expired;
	assign o_hi         = o_req && (starve || expired || quarter);
	assign o_alloc_hdr  = alloc_hdr_reg;
	assign o_alloc_data = alloc_data_reg;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	property p_alloc_drain;
		(i_drain && i_clk_en) |=> alloc_data_reg ==
			$past(alloc_data_reg) + $past(i_drain_data);
	endproperty
	a_alloc_drain: assert property (p_alloc_drain)
		else $error("allocated data not raised by drained credits");

	property p_sent_capture;
		(i_sent && i_clk_en) |=> last_data_reg == $past(alloc_data_reg)
			&& timer_reg == '0;
	endproperty
	a_sent_capture: assert property (p_sent_capture)
		else $error("send did not capture allocation or restart timer");

	property p_timer_hi;
		(timer_reg == TMAX) |-> o_hi;
	endproperty
	a_timer_hi: assert property (p_timer_hi)
		else $error("expired timer did not raise priority");

	property p_quarter_hi;
		(o_req && (alloc_data_reg - last_data_reg) >= QTR_DATA) |-> o_hi;
	endproperty
	a_quarter_hi: assert property (p_quarter_hi)
		else $error("quarter of buffer freed but priority low");
endmodule // fcc_rx_class

// file: fcc_flow_ctrl.sv
// Function
// - separate limit and consumed per three classes
// - limit loaded at init, refreshed by updates
// - send only if limit minus consumed suffices
// - header and data checked apart, one header
// - selected packet raises both consumed counters
// - allocated counter starts at buffer space
// - allocation grows after whole packet drained
// - update carries current allocated count
// - update requests normally at low priority
// - near-starved partner raises update priority
// - thirty microsecond timer raises priority
// - quarter of buffer freed raises priority
// - granted update waits for packet in flight
// - received update unblocks stalled packets
// - drain to update send takes eight cycles
// - received update reaches limit in fifteen
`timescale 1ns/1ns
module fcc_flow_ctrl import fcc_pkg::*; (
	input  wire logic      i_clock,
	input  wire logic      i_sys_rst,
	input  wire logic      i_clk_en,
	input  wire logic      i_tx_req,
	input  wire fcc_cls_t  i_tx_class,
	input  wire fcc_data_t i_tx_data_cred,
	output logic           o_tx_grant,
	input  wire logic      i_fc_valid,
	input  wire fcc_cls_t  i_fc_class,
	input  wire fcc_hdr_t  i_fc_hdr,
	input  wire fcc_data_t i_fc_data,
	input  wire logic      i_rx_valid,
	input  wire fcc_cls_t  i_rx_class,
	input  wire fcc_data_t i_rx_data_cred,
	input  wire logic      i_drain_done,
	input  wire fcc_cls_t  i_drain_class,
	input  wire fcc_hdr_t  i_drain_hdr,
	input  wire fcc_data_t i_drain_data,
	input  wire logic      i_tlp_busy,
	input  wire logic      i_upd_grant,
	output logic           o_upd_req,
	output logic           o_upd_hi,
	output logic           o_upd_valid,
	output fcc_cls_t       o_upd_class,
	output fcc_hdr_t       o_upd_hdr,
	output fcc_data_t      o_upd_data
);
	localparam int LAST = FCU_STAGES - 1;

	// transmit credit state
	fcc_hdr_t  lim_hdr_reg   [NUM_CLASS];
	fcc_hdr_t  lim_hdr_next  [NUM_CLASS];
	fcc_data_t lim_data_reg  [NUM_CLASS];
	fcc_data_t lim_data_next [NUM_CLASS];
	fcc_hdr_t  cons_hdr_reg  [NUM_CLASS];
	fcc_hdr_t  cons_hdr_next [NUM_CLASS];
	fcc_data_t cons_data_reg [NUM_CLASS];
	fcc_data_t cons_data_next[NUM_CLASS];
	logic      pipe_vld_reg  [FCU_STAGES];
	logic      pipe_vld_next [FCU_STAGES];
	fcc_cls_t  pipe_cls_reg  [FCU_STAGES];
	fcc_cls_t  pipe_cls_next [FCU_STAGES];
	fcc_hdr_t  pipe_hdr_reg  [FCU_STAGES];
	fcc_hdr_t  pipe_hdr_next [FCU_STAGES];
	fcc_data_t pipe_data_reg [FCU_STAGES];
	fcc_data_t pipe_data_next[FCU_STAGES];
	fcc_hdr_t  avail_hdr;
	fcc_data_t avail_data;
	logic      cls_ok;

	// receive side per class
	fcc_hdr_t  alloc_hdr [NUM_CLASS];
	fcc_data_t alloc_data[NUM_CLASS];
	logic      cls_req   [NUM_CLASS];
	logic      cls_hi    [NUM_CLASS];
	logic      cls_sent  [NUM_CLASS];

	// update arbitration state
	fcc_upd_state_e state_reg, state_next;
	fcc_cls_t       held_reg, held_next;
	logic           valid_reg, valid_next;
	fcc_cls_t       ocls_reg, ocls_next;
	fcc_hdr_t       ohdr_reg, ohdr_next;
	fcc_data_t      odata_reg, odata_next;
	fcc_cls_t       sel_cls, emit_cls;
	logic           any_req, sel_hi, emit;
	fcc_hdr_t       emit_hdr;
	fcc_data_t      emit_data;

	// credit check for the offered packet
	always_comb begin
		avail_hdr  = '0;
		avail_data = '0;
		cls_ok     = 1'b0;
		for (int c = 0; c < NUM_CLASS; c++) begin
			if (i_tx_class == CLS_W'(c)) begin
				avail_hdr  = lim_hdr_reg[c] - cons_hdr_reg[c];
				avail_data = lim_data_reg[c] - cons_data_reg[c];
				cls_ok     = 1'b1;
			end
		end
	end

	assign o_tx_grant = i_tx_req && cls_ok
		&& (avail_hdr >= HDR_CRED_PER_TLP)
		&& (avail_data >= i_tx_data_cred);

	always_comb begin
		for (int c = 0; c < NUM_CLASS; c++) begin
			lim_hdr_next[c]   = lim_hdr_reg[c];
			lim_data_next[c]  = lim_data_reg[c];
			cons_hdr_next[c]  = cons_hdr_reg[c];
			cons_data_next[c] = cons_data_reg[c];
			if (o_tx_grant && i_tx_class == CLS_W'(c)) begin
				cons_hdr_next[c]  = cons_hdr_reg[c] + HDR_CRED_PER_TLP;
				cons_data_next[c] = cons_data_reg[c] + i_tx_data_cred;
			end
			if (pipe_vld_reg[LAST] && pipe_cls_reg[LAST] == CLS_W'(c)) begin
				lim_hdr_next[c]  = pipe_hdr_reg[LAST];
				lim_data_next[c] = pipe_data_reg[LAST];
			end
		end
		// init and update values share the same latency path
		pipe_vld_next[0]  = i_fc_valid;
		pipe_cls_next[0]  = i_fc_class;
		pipe_hdr_next[0]  = i_fc_hdr;
		pipe_data_next[0] = i_fc_data;
		for (int s = 1; s < FCU_STAGES; s++) begin
			pipe_vld_next[s]  = pipe_vld_reg[s-1];
			pipe_cls_next[s]  = pipe_cls_reg[s-1];
			pipe_hdr_next[s]  = pipe_hdr_reg[s-1];
			pipe_data_next[s] = pipe_data_reg[s-1];
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			for (int c = 0; c < NUM_CLASS; c++) begin
				lim_hdr_reg[c]   <= '0;
				lim_data_reg[c]  <= '0;
				cons_hdr_reg[c]  <= '0;
				cons_data_reg[c] <= '0;
			end
			for (int s = 0; s < FCU_STAGES; s++) begin
				pipe_vld_reg[s]  <= 1'b0;
				pipe_cls_reg[s]  <= '0;
				pipe_hdr_reg[s]  <= '0;
				pipe_data_reg[s] <= '0;
			end
		end else if (i_clk_en) begin
			lim_hdr_reg   <= lim_hdr_next;
			lim_data_reg  <= lim_data_next;
			cons_hdr_reg  <= cons_hdr_next;
			cons_data_reg <= cons_data_next;
			pipe_vld_reg  <= pipe_vld_next;
			pipe_cls_reg  <= pipe_cls_next;
			pipe_hdr_reg  <= pipe_hdr_next;
			pipe_data_reg <= pipe_data_next;
		end
	end

	for (genvar g = 0; g < NUM_CLASS; g++) begin : g_rx
		fcc_rx_class #(
			.HDR_TOTAL  (RX_HDR_TOTAL[g]),
			.DATA_TOTAL (RX_DATA_TOTAL[g])
		) u_rx (
			.i_clock      (i_clock),
			.i_sys_rst    (i_sys_rst),
			.i_clk_en     (i_clk_en),
			.i_drain      (i_drain_done && i_drain_class == CLS_W'(g)),
			.i_drain_hdr  (i_drain_hdr),
			.i_drain_data (i_drain_data),
			.i_recv       (i_rx_valid && i_rx_class == CLS_W'(g)),
			.i_recv_data  (i_rx_data_cred),
			.i_sent       (cls_sent[g]),
			.o_alloc_hdr  (alloc_hdr[g]),
			.o_alloc_data (alloc_data[g]),
			.o_req        (cls_req[g]),
			.o_hi         (cls_hi[g])
		);
	end

	// pick a class: urgent first, then lowest index
	always_comb begin
		any_req = 1'b0;
		sel_hi  = 1'b0;
		sel_cls = '0;
		for (int c = NUM_CLASS - 1; c >= 0; c--) begin
			if (cls_req[c] && !(sel_hi && !cls_hi[c])) begin
				sel_cls = CLS_W'(c);
				sel_hi  = cls_hi[c];
			end
			any_req = any_req || cls_req[c];
		end
	end

	assign o_upd_req = (state_reg == UPD_IDLE) && any_req;
	assign o_upd_hi  = o_upd_req && sel_hi;
	assign emit_cls  = (state_reg == UPD_HOLD) ? held_reg : sel_cls;
	assign emit      = !i_tlp_busy && ((state_reg == UPD_HOLD)
		|| (o_upd_req && i_upd_grant));

	always_comb begin
		emit_hdr  = '0;
		emit_data = '0;
		for (int c = 0; c < NUM_CLASS; c++) begin
			cls_sent[c] = emit && emit_cls == CLS_W'(c);
			if (emit_cls == CLS_W'(c)) begin
				emit_hdr  = alloc_hdr[c];
				emit_data = alloc_data[c];
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		held_next  = held_reg;
		valid_next = emit;
		ocls_next  = ocls_reg;
		ohdr_next  = ohdr_reg;
		odata_next = odata_reg;
		unique case (state_reg)
			UPD_IDLE: begin
				if (o_upd_req && i_upd_grant && i_tlp_busy) begin
					state_next = UPD_HOLD;
					held_next  = sel_cls;
				end
			end
			UPD_HOLD: begin
				if (!i_tlp_busy) begin
					state_next = UPD_IDLE;
				end
			end
		endcase
		if (emit) begin
			ocls_next  = emit_cls;
			ohdr_next  = emit_hdr;
			odata_next = emit_data;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			state_reg <= UPD_IDLE;
			held_reg  <= '0;
			valid_reg <= 1'b0;
			ocls_reg  <= '0;
			ohdr_reg  <= '0;
			odata_reg <= '0;
		end else if (i_clk_en) begin
			state_reg <= state_next;
			held_reg  <= held_next;
			valid_reg <= valid_next;
			ocls_reg  <= ocls_next;
			ohdr_reg  <= ohdr_next;
			odata_reg <= odata_next;
		end
	end

	assign o_upd_valid = valid_reg;
	assign o_upd_class = ocls_reg;
	assign o_upd_hdr   = ohdr_reg;
	assign o_upd_data  = odata_reg;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	property p_grant_credit;
		o_tx_grant |-> (avail_data >= i_tx_data_cred) && cls_ok;
	endproperty
	a_grant_credit: assert property (p_grant_credit)
		else $error("packet granted without enough data credits");

	property p_grant_hdr;
		o_tx_grant |-> avail_hdr != '0;
	endproperty
	a_grant_hdr: assert property (p_grant_hdr)
		else $error("packet granted without a header credit");

	property p_cons_inc;
		(o_tx_grant && i_clk_en && i_tx_class == CLS_POSTED) |=>
			cons_hdr_reg[0] == $past(cons_hdr_reg[0]) + HDR_CRED_PER_TLP
			&& cons_data_reg[0] == $past(cons_data_reg[0])
			+ $past(i_tx_data_cred);
	endproperty
	a_cons_inc: assert property (p_cons_inc)
		else $error("consumed counters not raised by packet credits");

	property p_class_apart;
		(o_tx_grant && i_clk_en && i_tx_class == CLS_POSTED) |=>
			cons_hdr_reg[1] == $past(cons_hdr_reg[1]);
	endproperty
	a_class_apart: assert property (p_class_apart)
		else $error("packet charged to another class");

	property p_limit_applied;
		(pipe_vld_reg[LAST] && i_clk_en && pipe_cls_reg[LAST] == CLS_CPL)
			|=> lim_data_reg[2] == $past(pipe_data_reg[LAST]);
	endproperty
	a_limit_applied: assert property (p_limit_applied)
		else $error("received update not loaded into limit");

	property p_tlp_wait;
		(state_reg == UPD_HOLD && i_tlp_busy) |=>
			!o_upd_valid && state_reg == UPD_HOLD;
	endproperty
	a_tlp_wait: assert property (p_tlp_wait)
		else $error("update sent during packet in flight");

	sequence s_drain_posted;
		i_drain_done && i_clk_en && i_drain_class == CLS_POSTED;
	endsequence

	// no send and no second drain while the hold counts down
	sequence s_hold_quiet;
		i_clk_en && !cls_sent[0]
			&& !(i_drain_done && i_drain_class == CLS_POSTED);
	endsequence

	property p_drain_req;
		s_drain_posted ##1 s_hold_quiet [*6] |=> cls_req[0];
	endproperty
	a_drain_req: assert property (p_drain_req)
		else $error("drain did not request update in time");

	property p_grant_send;
		(o_upd_req && i_upd_grant && !i_tlp_busy && i_clk_en) |=>
			o_upd_valid && o_upd_data == $past(emit_data);
	endproperty
	a_grant_send: assert property (p_grant_send)
		else $error("granted update not sent next cycle");

	property p_hi_first;
		(o_upd_req && (cls_hi[0] || cls_hi[1] || cls_hi[2])) |->
			o_upd_hi && cls_hi[sel_cls];
	endproperty
	a_hi_first: assert property (p_hi_first)
		else $error("urgent update not presented at high priority");

	property p_hold_emit;
		(state_reg == UPD_HOLD && !i_tlp_busy && i_clk_en) |=>
			o_upd_valid && o_upd_class == $past(held_reg);
	endproperty
	a_hold_emit: assert property (p_hold_emit)
		else $error("held update not sent once the link was free");
endmodule // fcc_flow_ctrl

// file: fcc_link_partner.sv
`timescale 1ns/1ns
module fcc_link_partner import fcc_pkg::*; (
	input  wire logic i_clock,
	output logic      o_fc_valid,
	output fcc_cls_t  o_fc_class,
	output fcc_hdr_t  o_fc_hdr,
	output fcc_data_t o_fc_data
);
	initial begin
		o_fc_valid = 1'b0;
		o_fc_class = 2'h3;
		o_fc_hdr   = 8'hff;
		o_fc_data  = 12'hfff;
	end

	// absolute credit limits, one pulse, called at a falling edge
	task automatic send_fc(fcc_cls_t c, fcc_hdr_t h, fcc_data_t d);
		o_fc_valid = 1'b1;
		o_fc_class = c;
		o_fc_hdr   = h;
		o_fc_data  = d;
		@(negedge i_clock);
		// released fields show junk, never the last value
		o_fc_valid = 1'b0;
		o_fc_class = ~c;
		o_fc_hdr   = ~h;
		o_fc_data  = ~d;
	endtask
endmodule // fcc_link_partner

// file: tb_pcie_flow_control_credits.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_pcie_flow_control_credits import fcc_pkg::*; ;
	logic        i_clock = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        i_clk_en = 1'b1;
	logic        i_tx_req = 1'b0;
	fcc_cls_t    i_tx_class = 2'h0;
	fcc_data_t   i_tx_data_cred = 12'h000;
	logic        i_rx_valid = 1'b0;
	fcc_cls_t    i_rx_class = 2'h0;
	fcc_data_t   i_rx_data_cred = 12'h000;
	logic        i_drain_done = 1'b0;
	fcc_cls_t    i_drain_class = 2'h0;
	fcc_hdr_t    i_drain_hdr = 8'h00;
	fcc_data_t   i_drain_data = 12'h000;
	logic        i_tlp_busy = 1'b0;
	logic        i_upd_grant = 1'b1;
	logic        fc_valid, o_tx_grant, o_upd_req, o_upd_hi, o_upd_valid, ok;
	fcc_cls_t    fc_class, o_upd_class;
	fcc_hdr_t    fc_hdr, o_upd_hdr, lim_h;
	fcc_hdr_t    cons_h = 8'h00;
	fcc_data_t   fc_data, o_upd_data, lim_d, need;
	fcc_data_t   cons_d = 12'h000;
	logic [7:0]  st_q [$];
	logic [21:0] upd_q [$];
	logic [7:0]  e_st;
	logic [21:0] e_upd;
	int          n_fail = 0;
	int          checks_done = 0;
	int          seed = 32'h54658ad4;
	int          wait_n;

	always #4 i_clock = ~i_clock;

	fcc_flow_ctrl uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
		.i_clk_en(i_clk_en), .i_tx_req(i_tx_req),
		.i_tx_class(i_tx_class),
		.i_tx_data_cred(i_tx_data_cred), .o_tx_grant(o_tx_grant),
		.i_fc_valid(fc_valid), .i_fc_class(fc_class), .i_fc_hdr(fc_hdr),
		.i_fc_data(fc_data), .i_rx_valid(i_rx_valid),
		.i_rx_class(i_rx_class), .i_rx_data_cred(i_rx_data_cred),
		.i_drain_done(i_drain_done), .i_drain_class(i_drain_class),
		.i_drain_hdr(i_drain_hdr), .i_drain_data(i_drain_data),
		.i_tlp_busy(i_tlp_busy), .i_upd_grant(i_upd_grant),
		.o_upd_req(o_upd_req), .o_upd_hi(o_upd_hi),
		.o_upd_valid(o_upd_valid), .o_upd_class(o_upd_class),
		.o_upd_hdr(o_upd_hdr), .o_upd_data(o_upd_data));

	fcc_link_partner lp (.i_clock(i_clock), .o_fc_valid(fc_valid),
		.o_fc_class(fc_class), .o_fc_hdr(fc_hdr), .o_fc_data(fc_data));

	// status bits: grant, update request, high priority, update valid
	always @(negedge i_clock) begin
		#1;
		while (st_q.size() > 0) begin
			e_st = st_q.pop_front();
			`CHK({o_tx_grant, o_upd_req, o_upd_hi, o_upd_valid} & e_st[7:4], e_st[3:0])
		end
		if (o_upd_valid === 1'b1) begin
			`CHK(upd_q.size() > 0, 1'b1)
			if (upd_q.size() > 0) begin
				e_upd = upd_q.pop_front();
				`CHK({o_upd_class, o_upd_hdr, o_upd_data}, e_upd)
			end
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic tick(int n);
		repeat (n) @(negedge i_clock);
	endtask

	task automatic note(logic [3:0] m, logic [3:0] e);
		st_q.push_back({m, e});
	endtask

	task automatic offer(fcc_cls_t c, fcc_data_t d, logic g);
		i_tx_req = 1'b1;
		i_tx_class = c;
		i_tx_data_cred = d;
		note(4'h8, {g, 3'h0});
	endtask

	// limit lands in cycle 15 after the pulse, not before
	task automatic wait_fc(fcc_data_t d);
		for (int k = 1; k <= 15; k++) begin
			offer(CLS_POSTED, d, k == 15);
			tick(1);
		end
	endtask

	task automatic drain(fcc_cls_t c, fcc_hdr_t h, fcc_data_t d);
		i_drain_done = 1'b1;
		i_drain_class = c;
		i_drain_hdr = h;
		i_drain_data = d;
		tick(1);
		i_drain_done = 1'b0;
	endtask

	task automatic upd_walk(logic hi, fcc_cls_t c, fcc_hdr_t h, fcc_data_t d);
		upd_q.push_back({c, h, d});
		tick(5);
		note(4'h4, 4'h0);
		tick(1);
		note(4'h6, {2'h1, hi, 1'b0});
		tick(1);
		note(4'h1, 4'h1);
		tick(1);
	endtask

	initial begin
		tick(10);
		i_sys_rst = 1'b0;
		note(4'h4, 4'h0);
		offer(CLS_POSTED, 12'h000, 1'b0);
		tick(1);
		lp.send_fc(CLS_POSTED, 8'h02, 12'h00a);
		wait_fc(12'h00a);
		offer(CLS_POSTED, 12'h001, 1'b0);
		tick(1);
		offer(CLS_POSTED, 12'h000, 1'b1);
		tick(1);
		offer(CLS_POSTED, 12'h000, 1'b0);
		tick(1);
		offer(2'h3, 12'h000, 1'b0);
		tick(1);
		offer(CLS_NONPOSTED, 12'h000, 1'b0);
		tick(1);
		lp.send_fc(CLS_POSTED, 8'h04, 12'h010);
		wait_fc(12'h006);
		$display("test credit check ended");
		for (int it = 0; it < 16; it++) begin
			i_tx_req = 1'b0;
			lim_h = cons_h + 8'h02;
			lim_d = cons_d + fcc_data_t'($random(seed) & 32'h3ff);
			lp.send_fc(CLS_CPL, lim_h, lim_d);
			tick(15);
			repeat (3) begin
				need = fcc_data_t'($random(seed) & 32'h1ff);
				ok = fcc_hdr_t'(lim_h - cons_h) >= 8'h01 &&
					fcc_data_t'(lim_d - cons_d) >= need;
				offer(CLS_CPL, need, ok);
				tick(1);
				if (ok) begin
					cons_h = cons_h + 8'h01;
					cons_d = cons_d + need;
				end
			end
		end
		i_tx_req = 1'b0;
		$display("test random wrap ended");
		drain(CLS_NONPOSTED, 8'h01, 12'h004);
		upd_walk(1'b0, CLS_NONPOSTED, 8'h21, 12'h044);
		i_rx_valid = 1'b1;
		i_rx_class = CLS_NONPOSTED;
		i_rx_data_cred = 12'h03d;
		tick(1);
		i_rx_valid = 1'b0;
		drain(CLS_NONPOSTED, 8'h01, 12'h001);
		upd_walk(1'b1, CLS_NONPOSTED, 8'h22, 12'h045);
		drain(CLS_CPL, 8'h01, 12'h040);
		upd_walk(1'b1, CLS_CPL, 8'h21, 12'h140);
		$display("test update path ended");
		i_tlp_busy = 1'b1;
		drain(CLS_POSTED, 8'h01, 12'h004);
		upd_q.push_back({CLS_POSTED, 8'h21, 12'h084});
		tick(6);
		note(4'h4, 4'h4);
		tick(1);
		note(4'h5, 4'h0);
		tick(2);
		i_tlp_busy = 1'b0;
		note(4'h1, 4'h0);
		tick(1);
		note(4'h1, 4'h1);
		tick(1);
		$display("test busy link ended");
		i_upd_grant = 1'b0;
		wait_n = 0;
		while (o_upd_req !== 1'b1 && wait_n < 4000) begin
			tick(1);
			wait_n++;
		end
		`CHK(wait_n > 3600 && wait_n < 4000, 1'b1)
		note(4'h6, 4'h6);
		upd_q.push_back({CLS_NONPOSTED, 8'h22, 12'h045});
		upd_q.push_back({CLS_CPL, 8'h21, 12'h140});
		upd_q.push_back({CLS_POSTED, 8'h21, 12'h084});
		i_upd_grant = 1'b1;
		tick(60);
		`CHK(upd_q.size(), 0)
		$display("test update timer ended");
		i_clk_en = 1'b0;
		repeat (3) begin
			offer(CLS_POSTED, 12'h000, 1'b1);
			tick(1);
		end
		i_clk_en = 1'b1;
		offer(CLS_POSTED, 12'h000, 1'b1);
		tick(1);
		offer(CLS_POSTED, 12'h000, 1'b0);
		tick(1);
		i_tx_req = 1'b0;
		i_sys_rst = 1'b1;
		tick(2);
		i_sys_rst = 1'b0;
		offer(CLS_POSTED, 12'h000, 1'b0);
		note(4'h5, 4'h0);
		tick(1);
		i_tx_req = 1'b0;
		$display("test freeze and reset ended");
		give_verdict();
	end

	initial begin
		#200000;
		n_fail++;
		give_verdict();
	end
endmodule // tb_pcie_flow_control_credits
